// file: verilog/iaml_pkg.sv
package iaml_pkg;
  localparam int N_IRQ = 5;
  localparam int N_INT = 21;
  localparam int N_SRC = 26;
  // Avalon offsets (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PRIO = 8'h04;
  localparam logic [7:0] A_CCR  = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_EVT  = 8'h10;
  localparam logic [7:0] A_EMSK = 8'h14;
  // Field positions
  localparam int B_UE      = 0;
  localparam int B_IRQEN   = 1;
  localparam int B_GMASK   = 7;
  localparam int B_UMASK   = 6;
  localparam int E_MSK     = 0;
  localparam int E_NMI     = 1;
  localparam int N_EVT     = 2;
  // Reset values, and the fixed NMI vector number
  localparam logic        UE_RST   = 1'b1;
  localparam logic [15:0] PRIO_RST = 16'h0000;
  localparam logic        GM_RST   = 1'b1;
  localparam logic        UM_RST   = 1'b0;
  localparam logic [5:0]  NMI_VEC  = 6'h07;
  // Vector number per source, smallest first = default order
  localparam logic [5:0] SRC_VEC [N_SRC] = '{
    6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h14, 6'h18, 6'h19, 6'h1A,
    6'h1C, 6'h1D, 6'h1E, 6'h20, 6'h21, 6'h22, 6'h24, 6'h25, 6'h26,
    6'h28, 6'h29, 6'h2A, 6'h34, 6'h35, 6'h36, 6'h37, 6'h3C};
  // Bit of {reg_a, reg_b} holding each source's level
  localparam logic [3:0] SRC_LVL [N_SRC] = '{
    4'hF, 4'hE, 4'hD, 4'hD, 4'hC, 4'hB, 4'hA, 4'hA, 4'hA,
    4'h9, 4'h9, 4'h9, 4'h8, 4'h8, 4'h8, 4'h7, 4'h7, 4'h7,
    4'h6, 4'h6, 4'h6, 4'h3, 4'h3, 4'h3, 4'h3, 4'h1};

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_WAIT = 5'h02,
    S_SAVE = 5'h04,
    S_MASK = 5'h08,
    S_VECT = 5'h10
  } iaml_state_t;

  typedef struct packed {
    logic       valid;
    logic       nmi;
    logic       prio;
    logic [4:0] idx;
  } iaml_sel_t;

  typedef struct packed {
    logic [7:0]  condition_code_register;
    logic [23:0] pc;
  } iaml_push_t;
endpackage : iaml_pkg

// file: verilog/iaml_top.sv
module iaml_top (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Avalon-MM slave
  input  wire logic [7:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // Pins
  input  wire logic                      nmi_pin,
  input  wire logic [iaml_pkg::N_IRQ-1:0] irq_pin,
  input  wire logic                      standby_pin,
  // On-chip sources
  input  wire logic [iaml_pkg::N_INT-1:0] src_flag,
  input  wire logic [iaml_pkg::N_INT-1:0] src_enable,
  // CPU core
  input  wire logic                      cpu_instr_end,
  input  wire logic [23:0]               cpu_pc,
  input  wire logic [5:0]                cpu_ccr_low,
  output logic                           stack_push_valid,
  output iaml_pkg::iaml_push_t           stack_push,
  output logic                           vec_valid,
  output logic      [15:0]               vec_addr,
  output logic                           exc_busy,
  // Interrupt
  output logic                           irq_out
);
  logic [iaml_pkg::N_IRQ-1:0] irq_s1_q, irq_s2_q;
  logic nmi_s1_q, nmi_s2_q, nmi_d1_q, sb_s1_q, sb_s2_q;
  logic ue_q;
  logic [iaml_pkg::N_IRQ-1:0] irqen_q;
  logic [15:0] prio_q;
  logic gmask_q, umask_q;
  logic nmi_pend_q;
  logic [iaml_pkg::N_EVT-1:0] evt_q, emsk_q, evt_set;
  logic [iaml_pkg::N_SRC-1:0] req, lvl;
  iaml_pkg::iaml_sel_t sel;
  iaml_pkg::iaml_state_t state_q, state_d;
  logic [5:0] vec_q;
  logic nmi_taken_q;
  logic take, take_nmi, mask_ok;
  logic ack_q, bus_req, wr_go, rd_go;
  logic [31:0] rd_d;

  // Pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_s1_q <= '0;
      irq_s2_q <= '0;
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_d1_q <= 1'b0;
      sb_s1_q  <= 1'b0;
      sb_s2_q  <= 1'b0;
    end else begin
      irq_s1_q <= irq_pin;
      irq_s2_q <= irq_s1_q;
      nmi_s1_q <= nmi_pin;
      nmi_s2_q <= nmi_s1_q;
      nmi_d1_q <= nmi_s2_q;
      sb_s1_q  <= standby_pin;
      sb_s2_q  <= sb_s1_q;
    end
  end

  // Source gating and per-source level
  assign req = {src_flag & src_enable, irq_s2_q & irqen_q};
  generate
    for (genvar g = 0; g < iaml_pkg::N_SRC; g++) begin : g_lvl
      assign lvl[g] = prio_q[iaml_pkg::SRC_LVL[g]];
    end
  endgenerate

  // Table is in vector order, so the lowest index wins a tie
  function automatic iaml_pkg::iaml_sel_t pick(
    input logic [iaml_pkg::N_SRC-1:0] r,
    input logic [iaml_pkg::N_SRC-1:0] l
  );
    iaml_pkg::iaml_sel_t s;
    s = '0;
    for (int i = iaml_pkg::N_SRC - 1; i >= 0; i--) begin
      if (r[i] && !l[i]) begin
        s.valid = 1'b1;
        s.prio  = 1'b0;
        s.idx   = i[4:0];
      end
    end
    for (int i = iaml_pkg::N_SRC - 1; i >= 0; i--) begin
      if (r[i] && l[i]) begin
        s.valid = 1'b1;
        s.prio  = 1'b1;
        s.idx   = i[4:0];
      end
    end
    return s;
  endfunction : pick

  always_comb begin
    sel = pick(req, lvl);
    if (nmi_pend_q) begin
      sel.valid = 1'b1;
      sel.nmi   = 1'b1;
    end
  end

  // Acceptance
  always_comb begin
    if (ue_q) begin
      mask_ok = !gmask_q;
    end else begin
      mask_ok = !gmask_q || (sel.prio && !umask_q);
    end
  end
  // Standby blocks everything; reset holds the sequencer idle
  assign take_nmi = nmi_pend_q && !sb_s2_q;
  assign take = (state_q == iaml_pkg::S_IDLE) && !sb_s2_q && sel.valid
                && (sel.nmi || mask_ok);

  // NMI edge latch; a new edge wins over the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_s2_q && !nmi_d1_q) begin
      nmi_pend_q <= 1'b1;
    end else if (take && take_nmi) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // Exception sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      iaml_pkg::S_IDLE: if (take) state_d = iaml_pkg::S_WAIT;
      iaml_pkg::S_WAIT: if (cpu_instr_end) state_d = iaml_pkg::S_SAVE;
      iaml_pkg::S_SAVE: state_d = iaml_pkg::S_MASK;
      iaml_pkg::S_MASK: state_d = iaml_pkg::S_VECT;
      iaml_pkg::S_VECT: state_d = iaml_pkg::S_IDLE;
      default:          state_d = iaml_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= iaml_pkg::S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Capture the winner when it is accepted
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vec_q       <= '0;
      nmi_taken_q <= 1'b0;
    end else if (take) begin
      vec_q       <= sel.nmi ? iaml_pkg::NMI_VEC : iaml_pkg::SRC_VEC[sel.idx];
      nmi_taken_q <= sel.nmi;
    end
  end

  // Stack push: core's PC at the boundary is the resume address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stack_push_valid <= 1'b0;
      stack_push       <= '0;
    end else begin
      stack_push_valid <= (state_q == iaml_pkg::S_SAVE);
      if (state_q == iaml_pkg::S_SAVE) begin
        stack_push.pc  <= cpu_pc;
        stack_push.condition_code_register <= {gmask_q, umask_q, cpu_ccr_low};
      end
    end
  end

  // Vector output, four bytes per entry
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vec_valid <= 1'b0;
      vec_addr  <= '0;
    end else begin
      vec_valid <= (state_q == iaml_pkg::S_VECT);
      if (state_q == iaml_pkg::S_VECT) begin
        vec_addr <= {8'h00, vec_q, 2'b00};
      end
    end
  end

  assign exc_busy = (state_q != iaml_pkg::S_IDLE);

  // One wait state; a write lands only at the edge where waitrequest is low
  assign bus_req         = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack_q;
  assign wr_go           = avs_write && ack_q;
  assign rd_go           = avs_read && !ack_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q;
    end
  end

  always_comb begin
    rd_d = '0;
    if (avs_address == iaml_pkg::A_CTRL) begin
      rd_d[iaml_pkg::B_UE] = ue_q;
      rd_d[iaml_pkg::B_IRQEN +: iaml_pkg::N_IRQ] = irqen_q;
    end else if (avs_address == iaml_pkg::A_PRIO) begin
      rd_d[15:0] = prio_q;
    end else if (avs_address == iaml_pkg::A_CCR) begin
      rd_d[iaml_pkg::B_GMASK] = gmask_q;
      rd_d[iaml_pkg::B_UMASK] = umask_q;
    end else if (avs_address == iaml_pkg::A_STAT) begin
      rd_d[5:0]   = vec_q;
      rd_d[8]     = nmi_taken_q;
      rd_d[20:16] = state_q;
    end else if (avs_address == iaml_pkg::A_EVT) begin
      rd_d[iaml_pkg::N_EVT-1:0] = evt_q;
    end else if (avs_address == iaml_pkg::A_EMSK) begin
      rd_d[iaml_pkg::N_EVT-1:0] = emsk_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (rd_go) begin
      avs_readdata <= rd_d;
    end
  end

  // Control registers; default order after reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ue_q    <= iaml_pkg::UE_RST;
      irqen_q <= '0;
      prio_q  <= iaml_pkg::PRIO_RST;
      emsk_q  <= '0;
    end else if (wr_go) begin
      if (avs_address == iaml_pkg::A_CTRL) begin
        ue_q    <= avs_writedata[iaml_pkg::B_UE];
        irqen_q <= avs_writedata[iaml_pkg::B_IRQEN +: iaml_pkg::N_IRQ];
      end else if (avs_address == iaml_pkg::A_PRIO) begin
        prio_q <= avs_writedata[15:0];
      end else if (avs_address == iaml_pkg::A_EMSK) begin
        emsk_q <= avs_writedata[iaml_pkg::N_EVT-1:0];
      end
    end
  end

  // Mask bits: hardware set beats a software write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gmask_q <= iaml_pkg::GM_RST;
      umask_q <= iaml_pkg::UM_RST;
    end else if (state_q == iaml_pkg::S_MASK) begin
      gmask_q <= 1'b1;
      if (!ue_q) begin
        umask_q <= 1'b1;
      end
    end else if (wr_go && avs_address == iaml_pkg::A_CCR) begin
      gmask_q <= avs_writedata[iaml_pkg::B_GMASK];
      umask_q <= avs_writedata[iaml_pkg::B_UMASK];
    end
  end

  // Sticky events, write one to clear, set wins
  assign evt_set[iaml_pkg::E_MSK] = take && !sel.nmi;
  assign evt_set[iaml_pkg::E_NMI] = take && sel.nmi;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      evt_q <= '0;
    end else if (wr_go && avs_address == iaml_pkg::A_EVT) begin
      evt_q <= (evt_q & ~avs_writedata[iaml_pkg::N_EVT-1:0]) | evt_set;
    end else begin
      evt_q <= evt_q | evt_set;
    end
  end

  assign irq_out = |(evt_q & emsk_q);

  // Checks
  a_ue1_gmask: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_IDLE && ue_q && gmask_q && !nmi_pend_q)
    |=> state_q == iaml_pkg::S_IDLE)
    else $error("maskable taken with single-level mask set");

  a_ue1_level_free: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_IDLE && ue_q && !gmask_q && !sb_s2_q && sel.valid)
    |=> state_q == iaml_pkg::S_WAIT)
    else $error("request not taken with single-level mask clear");

  a_ue0_both_masks: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_IDLE && !ue_q && gmask_q && umask_q && !nmi_pend_q)
    |=> state_q == iaml_pkg::S_IDLE)
    else $error("maskable taken with both masks set");

  a_ue0_level_one: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_IDLE && !ue_q && gmask_q && !umask_q && !sb_s2_q
     && sel.valid && sel.prio) |=> state_q == iaml_pkg::S_WAIT)
    else $error("level one request not taken");

  a_ue0_open: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_IDLE && !ue_q && !gmask_q && !sb_s2_q && sel.valid)
    |=> state_q == iaml_pkg::S_WAIT)
    else $error("request not taken with mask clear");

  a_nmi_taken: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_IDLE && nmi_pend_q && !sb_s2_q)
    |=> (state_q == iaml_pkg::S_WAIT && nmi_taken_q && vec_q == iaml_pkg::NMI_VEC))
    else $error("NMI not taken");

  a_standby_block: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_IDLE && sb_s2_q) |=> state_q == iaml_pkg::S_IDLE)
    else $error("request taken in standby");

  a_wait_boundary: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_WAIT && !cpu_instr_end) |=> state_q == iaml_pkg::S_WAIT)
    else $error("handling began mid instruction");

  a_push_pc: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_SAVE) |=> (stack_push_valid && stack_push.pc == $past(cpu_pc)))
    else $error("stacked PC wrong");

  a_push_ccr: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_SAVE)
    |=> stack_push.condition_code_register == {$past(gmask_q), $past(umask_q), $past(cpu_ccr_low)})
    else $error("stacked condition codes wrong");

  a_mask_after: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_MASK) |=> (gmask_q && (ue_q || umask_q)))
    else $error("masks not set after save");

  a_vec_addr: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == iaml_pkg::S_VECT)
    |=> (vec_valid && vec_addr == {8'h00, $past(vec_q), 2'b00}))
    else $error("vector address wrong");

  a_src_enabled: assert property (@(posedge sys_clk) disable iff (rst)
    (sel.valid && !sel.nmi) |-> (req[sel.idx] && lvl[sel.idx] == sel.prio))
    else $error("selected source not requesting");

  a_level_first: assert property (@(posedge sys_clk) disable iff (rst)
    (sel.valid && !sel.nmi && !sel.prio) |-> !(|(req & lvl)))
    else $error("level zero chosen over level one");

  a_tie_lowest: assert property (@(posedge sys_clk) disable iff (rst)
    (sel.valid && !sel.nmi)
    |-> ((req & ~(lvl ^ {iaml_pkg::N_SRC{sel.prio}}))
         & ((iaml_pkg::N_SRC'(1) << sel.idx) - iaml_pkg::N_SRC'(1))) == '0)
    else $error("tie not broken by default order");
endmodule : iaml_top

// file: tb/iaml_cpu_model.sv
module iaml_cpu_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Sequence handshake
  input  wire logic        exc_busy,
  input  wire logic [3:0]  stall_cyc,
  output logic             cpu_instr_end,
  output logic      [23:0] cpu_pc,
  output logic      [5:0]  cpu_ccr_low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cnt_q;
  assign cpu_ccr_low = cpu_pc[6:1];
  // Instruction end is late by stall_cyc; the counter never wraps within one sequence
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q         <= 5'h00;
      cpu_instr_end <= 1'b0;
      cpu_pc        <= 24'h000100;
    end else if (exc_busy) begin
      cnt_q         <= cnt_q + 5'h01;
      cpu_instr_end <= (cnt_q == {1'b0, stall_cyc});
    end else begin
      cnt_q         <= 5'h00;
      cpu_instr_end <= 1'b0;
      cpu_pc        <= cpu_pc + 24'h000002;
    end
  end
endmodule : iaml_cpu_model

// file: tb/interrupt_accept_mask_logic_bench.sv
module interrupt_accept_mask_logic_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                         sys_clk;
  logic                         rst;
  logic                         avs_read;
  logic                         avs_write;
  logic                         avs_waitrequest;
  logic [7:0]                   avs_address;
  logic [31:0]                  avs_writedata;
  logic [31:0]                  avs_readdata;
  logic [31:0]                  rd;
  logic                         nmi_pin;
  logic                         standby_pin;
  logic [iaml_pkg::N_IRQ-1:0]   irq_pin;
  logic [iaml_pkg::N_INT-1:0]   src_flag;
  logic [iaml_pkg::N_INT-1:0]   src_enable;
  logic                         cpu_instr_end;
  logic [23:0]                  cpu_pc;
  logic [5:0]                   cpu_ccr_low;
  logic [3:0]                   stall_cyc;
  logic                         stack_push_valid;
  iaml_pkg::iaml_push_t         stack_push;
  logic                         vec_valid;
  logic [15:0]                  vec_addr;
  logic                         exc_busy;
  logic                         irq_out;
  int                           fails;
  int                           cmp_count;

  iaml_top u_dut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .nmi_pin(nmi_pin), .irq_pin(irq_pin),
    .standby_pin(standby_pin), .src_flag(src_flag), .src_enable(src_enable),
    .cpu_instr_end(cpu_instr_end), .cpu_pc(cpu_pc), .cpu_ccr_low(cpu_ccr_low),
    .stack_push_valid(stack_push_valid), .stack_push(stack_push), .vec_valid(vec_valid),
    .vec_addr(vec_addr), .exc_busy(exc_busy), .irq_out(irq_out)
  );

  iaml_cpu_model u_cpu (
    .sys_clk(sys_clk), .rst(rst), .exc_busy(exc_busy), .stall_cyc(stall_cyc),
    .cpu_instr_end(cpu_instr_end), .cpu_pc(cpu_pc), .cpu_ccr_low(cpu_ccr_low)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic results();
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Waitrequest and read data are taken at the rising edge that completes the access
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      results();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(rd, e);
  endtask : rd_chk

  task automatic wait_vec(input logic [5:0] v);
    int n;
    int pushes;
    logic got;
    got = 1'b0;
    pushes = 0;
    for (n = 0; n < 80 && !got; n++) begin
      @(negedge sys_clk);
      if (stack_push_valid === 1'b1) begin
        pushes++;
        chk(stack_push.pc, cpu_pc);
        chk(stack_push.condition_code_register[5:0], cpu_ccr_low);
      end
      if (vec_valid === 1'b1) got = 1'b1;
    end
    if (!got) begin
      fails++;
      results();
    end
    chk(pushes, 32'h00000001);
    chk(vec_addr, {8'h00, v, 2'b00});
    @(posedge sys_clk);
  endtask : wait_vec

  task automatic no_take(input int n);
    int b;
    b = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (exc_busy !== 1'b0) b++;
    end
    chk(b, 32'h00000000);
    @(posedge sys_clk);
  endtask : no_take

  initial begin
    fails = 0;
    cmp_count = 0;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    nmi_pin = 1'b0;
    standby_pin = 1'b0;
    irq_pin = '0;
    src_flag = '0;
    src_enable = '0;
    stall_cyc = 4'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(iaml_pkg::A_CTRL, 32'h00000001);
    rd_chk(iaml_pkg::A_PRIO, 32'h00000000);
    rd_chk(iaml_pkg::A_CCR, 32'h00000080);
    rd_chk(8'h18, 32'h00000000);
    $display("test reset done");
    // Flag without enable must stay invisible even when unmasked
    src_flag[0] <= 1'b1;
    bus(1'b1, iaml_pkg::A_CCR, 32'h00000000);
    no_take(12);
    // Mask first, so the enabled sources never see an open window
    bus(1'b1, iaml_pkg::A_CCR, 32'h00000080);
    src_enable[0] <= 1'b1;
    src_enable[4] <= 1'b1;
    src_flag[4]   <= 1'b1;
    no_take(12);
    stall_cyc <= 4'h9;
    bus(1'b1, iaml_pkg::A_CCR, 32'h00000040);
    wait_vec(6'h14);
    src_flag[0] <= 1'b0;
    stall_cyc <= 4'h0;
    bus(1'b1, iaml_pkg::A_CCR, 32'h00000000);
    wait_vec(6'h1C);
    rd_chk(iaml_pkg::A_CCR, 32'h00000080);
    $display("test single level done");
    rd_chk(iaml_pkg::A_EVT, 32'h00000001);
    @(negedge sys_clk);
    chk(irq_out, 32'h00000000);
    bus(1'b1, iaml_pkg::A_EMSK, 32'h00000001);
    @(negedge sys_clk);
    chk(irq_out, 32'h00000001);
    bus(1'b1, iaml_pkg::A_EVT, 32'h00000001);
    @(negedge sys_clk);
    chk(irq_out, 32'h00000000);
    rd_chk(iaml_pkg::A_EVT, 32'h00000000);
    $display("test event line done");
    // Source 4 sits behind the later vector but gets the higher level
    src_flag[0] <= 1'b1;
    bus(1'b1, iaml_pkg::A_PRIO, 32'h00000200);
    bus(1'b1, iaml_pkg::A_CCR, 32'h00000000);
    wait_vec(6'h1C);
    src_flag[4] <= 1'b0;
    bus(1'b1, iaml_pkg::A_CTRL, 32'h00000000);
    bus(1'b1, iaml_pkg::A_CCR, 32'h00000080);
    no_take(12);
    src_flag[4] <= 1'b1;
    wait_vec(6'h1C);
    rd_chk(iaml_pkg::A_CCR, 32'h000000C0);
    no_take(12);
    src_flag[4] <= 1'b0;
    bus(1'b1, iaml_pkg::A_CCR, 32'h00000040);
    wait_vec(6'h14);
    $display("test three level done");
    nmi_pin <= 1'b1;
    wait_vec(6'h07);
    rd_chk(iaml_pkg::A_STAT, 32'h00010107);
    rd_chk(iaml_pkg::A_EVT, 32'h00000003);
    nmi_pin <= 1'b0;
    standby_pin <= 1'b1;
    bus(1'b1, iaml_pkg::A_CCR, 32'h00000000);
    no_take(12);
    standby_pin <= 1'b0;
    wait_vec(6'h14);
    src_flag[0] <= 1'b0;
    $display("test nmi and standby done");
    bus(1'b1, iaml_pkg::A_CTRL, 32'h0000003F);
    for (int i = 0; i < 5; i++) begin
      irq_pin <= 5'h01 << i;
      bus(1'b1, iaml_pkg::A_CCR, 32'h00000000);
      wait_vec(6'h0C + 6'(i));
      irq_pin <= 5'h00;
      repeat (4) @(posedge sys_clk);
    end
    $display("test pins done");
    results();
  end
endmodule : interrupt_accept_mask_logic_bench
